// ### shared/dfe_defines.svh
// register offsets, field positions, codes and timing constants of the fault reporter
`ifndef DFE_DEFINES_SVH
`define DFE_DEFINES_SVH

`define DFE_OFS_CTRL        8'h00
`define DFE_OFS_STATUS      8'h04
`define DFE_OFS_IRQ_STAT    8'h08
`define DFE_OFS_IRQ_MASK    8'h0c
`define DFE_OFS_WINDOW      8'h10
`define DFE_OFS_TIMEOUT     8'h14
`define DFE_OFS_REACT       8'h18
`define DFE_OFS_HIST_CNT    8'h1c
`define DFE_OFS_COBID_BASE  8'h20
`define DFE_OFS_STORE_BASE  8'h30
`define DFE_OFS_HIST_BASE   8'h40

`define DFE_CTRL_CLR_BIT    0
`define DFE_ST_ERR_BIT      3
`define DFE_ST_TRK_BIT      13
`define DFE_ST_DUP_BIT      0
`define DFE_ST_OUT_BIT      1
`define DFE_ST_BLK_LSB      16

`define DFE_IRQ_DUP         0
`define DFE_IRQ_TRK         1
`define DFE_IRQ_SENT        2
`define DFE_IRQ_W           3

`define DFE_EMCY_DUP        16'h8150
`define DFE_EMCY_TRK        16'h8611
`define DFE_EMCY_RESET      16'h0000
`define DFE_NMT_RESET_NODE  8'h81

`define DFE_NODE_W          7
`define DFE_ID_INVALID_BIT  31
`define DFE_ID_MSB          10

`define DFE_DEF_COBID0      32'h0000_0080
`define DFE_DEF_COBID1      32'h0000_0200
`define DFE_DEF_COBID2      32'h0000_0300
`define DFE_DEF_COBID3      32'h0000_0180
`define DFE_WINDOW_RST      32'h0000_1000
`define DFE_TIMEOUT_RST     16'h0064
`define DFE_REACT_RST       3'h2
`define DFE_LOAD_WAIT       2'h2

`define DFE_CLK_PERIOD_PS   4000
`define DFE_TICK_PS         1000000
`define DFE_CYC_PER_TICK    (`DFE_TICK_PS / `DFE_CLK_PERIOD_PS)

`endif

// ### shared/dfe_pkg.sv
// types shared by the fault reporter modules
package dfe_pkg;
  typedef logic [31:0] dfe_word_t;
  typedef logic [15:0] dfe_code_t;
  typedef logic [2:0]  dfe_react_t;
  typedef enum logic [1:0] {
    DFE_TX_IDLE = 2'b01,
    DFE_TX_SEND = 2'b10
  } dfe_tx_state_t;
  typedef enum logic [1:0] {
    DFE_SRC_DUP = 2'd0,
    DFE_SRC_TRK = 2'd1,
    DFE_SRC_RST = 2'd2
  } dfe_src_t;
endpackage

// ### hw/dfe_dup_chk.sv
// duplicate identifier compare across the node's message objects
`timescale 1ns/1ps
`default_nettype none
`include "dfe_defines.svh"
module dfe_dup_chk #(
  parameter int NOBJ = 4
) (
  input  wire dfe_pkg::dfe_word_t [NOBJ-1:0] i_ids,  // current identifiers
  output logic [NOBJ-1:0]                    o_dup   // entry clashes with another
);
  import dfe_pkg::*;

  // invalid-flagged entries take no part in the compare
  for (genvar i = 0; i < NOBJ; i++) begin : g_obj
    always_comb begin
      o_dup[i] = 1'b0;
      for (int j = 0; j < NOBJ; j++) begin
        if (j != i && !i_ids[i][`DFE_ID_INVALID_BIT] && !i_ids[j][`DFE_ID_INVALID_BIT] &&
            i_ids[i][`DFE_ID_MSB:0] == i_ids[j][`DFE_ID_MSB:0]) begin
          o_dup[i] = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/dfe_trk_sup.sv
// position tracking-error supervisor with timeout in microsecond ticks
`timescale 1ns/1ps
`default_nettype none
`include "dfe_defines.svh"
module dfe_trk_sup #(
  parameter int PW = 32,
  parameter int TW = 16
) (
  input  wire logic                 i_clk,      // clock
  input  wire logic                 i_reset,    // async reset, high
  input  wire logic                 i_enable,   // supervision armed
  input  wire logic signed [PW-1:0] i_demand,   // demanded position
  input  wire logic signed [PW-1:0] i_actual,   // actual position
  input  wire logic [PW-1:0]        i_window,   // allowed error
  input  wire logic [TW-1:0]        i_timeout,  // timeout in ticks
  output logic                      o_outside,  // error outside window
  output logic                      o_trip      // one-cycle fault pulse
);
  localparam int PRE_W = $clog2(`DFE_CYC_PER_TICK);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(`DFE_CYC_PER_TICK - 1);

  logic signed [PW:0] diff;
  logic [PW:0]        mag;
  logic [PRE_W-1:0]   pre_q;
  logic [TW-1:0]      cnt_q;
  logic               done_q;

  always_comb begin
    diff = PW'(0) + ($signed({i_demand[PW-1], i_demand}) - $signed({i_actual[PW-1], i_actual}));
    mag  = diff[PW] ? (PW+1)'(-diff) : diff;
  end
  assign o_outside = mag > {1'b0, i_window};

  // counting restarts whenever the error comes back inside
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (!i_enable || !o_outside) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (pre_q == PRE_LAST) begin
      pre_q <= '0;
      if (cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      done_q <= 1'b0;
      o_trip <= 1'b0;
    end else begin
      // the trip flop itself blocks a second cycle before done_q can catch up
      o_trip <= i_enable && o_outside && !done_q && !o_trip && cnt_q > i_timeout;
      if (!i_enable) begin
        done_q <= 1'b0;
      end else if (o_trip) begin
        done_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/dfe_fault_report.sv
// fault supervision and emergency reporting: duplicate identifiers and tracking error
`timescale 1ns/1ps
`default_nettype none
`include "dfe_defines.svh"
module dfe_fault_report #(
  parameter int NOBJ   = 4,
  parameter int HDEPTH = 4
) (
  input  wire logic                             i_clk,          // clock, 250 MHz
  input  wire logic                             i_reset,        // async reset, high
  input  wire logic                             i_psel,         // apb select
  input  wire logic                             i_penable,      // apb enable
  input  wire logic                             i_pwrite,       // apb write
  input  wire logic [7:0]                       i_paddr,        // apb byte address
  input  wire dfe_pkg::dfe_word_t               i_pwdata,       // apb write data
  output dfe_pkg::dfe_word_t                    o_prdata,       // apb read data
  output logic                                  o_pready,       // apb ready
  output logic                                  o_pslverr,      // apb error
  input  wire logic [`DFE_NODE_W-1:0]           i_node_addr,    // node address pins
  input  wire logic                             i_nmt_valid,    // nmt command strobe
  input  wire logic [7:0]                       i_nmt_cmd,      // nmt command code
  input  wire logic signed [31:0]               i_pos_demand,   // demanded position
  input  wire logic signed [31:0]               i_pos_actual,   // actual position
  output logic                                  o_emcy_valid,   // emergency pending
  output dfe_pkg::dfe_code_t                    o_emcy_code,    // emergency code
  input  wire logic                             i_emcy_ready,   // emergency taken
  output dfe_pkg::dfe_word_t [NOBJ-1:0]         o_cob_id,       // live identifiers
  output logic [NOBJ-1:0]                       o_rx_block,     // reception blocked
  output logic                                  o_status_err,   // status word bit 3
  output logic                                  o_status_trk,   // status word bit 13
  output logic                                  o_react_req,    // fault reaction pulse
  output dfe_pkg::dfe_react_t                   o_react_code,   // selected reaction
  output logic                                  o_irq           // interrupt, high
);
  import dfe_pkg::*;

  localparam int HCW = $clog2(HDEPTH + 1);
  localparam dfe_word_t DEF_ID [4] = '{`DFE_DEF_COBID0, `DFE_DEF_COBID1,
                                       `DFE_DEF_COBID2, `DFE_DEF_COBID3};

  function automatic logic [7:0] slot(input logic [7:0] base, input int idx);
    slot = 8'(base + 8'(4 * idx));
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = a <= `DFE_OFS_HIST_CNT && a[1:0] == 2'h0;
    for (int k = 0; k < NOBJ; k++) begin
      if (a == slot(`DFE_OFS_COBID_BASE, k) || a == slot(`DFE_OFS_STORE_BASE, k)) begin
        mapped = 1'b1;
      end
    end
    for (int k = 0; k < HDEPTH; k++) begin
      if (a == slot(`DFE_OFS_HIST_BASE, k)) begin
        mapped = 1'b1;
      end
    end
  endfunction

  logic [`DFE_NODE_W-1:0] node_s1_q;
  logic [`DFE_NODE_W-1:0] node_s2_q;
  dfe_word_t              window_q;
  logic [15:0]            timeout_q;
  dfe_react_t             react_q;
  logic [`DFE_IRQ_W-1:0]  irq_stat_q;
  logic [`DFE_IRQ_W-1:0]  irq_mask_q;
  dfe_word_t              cob_q  [NOBJ];
  dfe_word_t              sto_q  [NOBJ];
  dfe_word_t              hist_q [HDEPTH];
  logic [HCW-1:0]         hcnt_q;
  logic                   ld_pend_q;
  logic [1:0]             ld_cnt_q;
  logic                   chk_q;
  logic [NOBJ-1:0]        dup;
  logic                   dup_rec_q;
  logic                   fault_q;
  logic [2:0]             pend_q;
  dfe_tx_state_t          tx_q;
  dfe_src_t               sel_q;
  dfe_word_t              rdata_d;
  logic                   outside;
  logic                   trip;
  logic                   acc_wr;
  logic                   do_load;
  logic                   sdo_id_wr;
  logic                   dup_set;
  logic                   clear_req;
  logic                   tx_done;
  logic [2:0]             pend_set;

  // apb: zero wait states, write lands at the access edge
  assign acc_wr    = i_psel && i_penable && i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);
  assign o_irq     = |(irq_stat_q & irq_mask_q);
  assign do_load   = ld_pend_q && ld_cnt_q == 2'h0;
  assign clear_req = acc_wr && i_paddr == `DFE_OFS_CTRL && i_pwdata[`DFE_CTRL_CLR_BIT] && fault_q;
  assign tx_done   = tx_q == DFE_TX_SEND && i_emcy_ready;
  assign o_emcy_valid = tx_q == DFE_TX_SEND;
  assign o_status_err = fault_q;
  assign o_status_trk = fault_q;

  always_comb begin
    sdo_id_wr = 1'b0;
    for (int k = 0; k < NOBJ; k++) begin
      if (acc_wr && i_paddr == slot(`DFE_OFS_COBID_BASE, k)) begin
        sdo_id_wr = 1'b1;
      end
    end
  end

  // node address pins pass two flops before use
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      node_s1_q <= '0;
      node_s2_q <= '0;
    end else begin
      node_s1_q <= i_node_addr;
      node_s2_q <= node_s1_q;
    end
  end

  // load stored parameters after reset release and on reset-node command
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ld_pend_q <= 1'b1;
      ld_cnt_q  <= `DFE_LOAD_WAIT;
    end else if (i_nmt_valid && i_nmt_cmd == `DFE_NMT_RESET_NODE) begin
      ld_pend_q <= 1'b1;
      ld_cnt_q  <= `DFE_LOAD_WAIT;
    end else if (ld_pend_q) begin
      if (ld_cnt_q != 2'h0) begin
        ld_cnt_q <= ld_cnt_q - 2'h1;
      end else begin
        ld_pend_q <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < NOBJ; i++) begin : g_obj
    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        cob_q[i] <= DEF_ID[i % 4];
        sto_q[i] <= DEF_ID[i % 4];
      end else begin
        if (do_load) begin
          cob_q[i] <= {sto_q[i][31:`DFE_NODE_W], node_s2_q};
        end else if (acc_wr && i_paddr == slot(`DFE_OFS_COBID_BASE, i)) begin
          cob_q[i] <= i_pwdata;
        end
        if (acc_wr && i_paddr == slot(`DFE_OFS_STORE_BASE, i)) begin
          sto_q[i] <= i_pwdata;
        end
      end
    end
    assign o_cob_id[i] = cob_q[i];
  end

  dfe_dup_chk #(
    .NOBJ (NOBJ)
  ) u_dup (
    .i_ids (o_cob_id),
    .o_dup (dup)
  );

  // compare one cycle after the identifiers change
  assign dup_set = chk_q && |dup;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      chk_q      <= 1'b0;
      o_rx_block <= '0;
    end else begin
      chk_q <= do_load || sdo_id_wr;
      if (chk_q) begin
        o_rx_block <= dup;
      end
    end
  end

  dfe_trk_sup #(
    .PW (32),
    .TW (16)
  ) u_trk (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_enable  (!fault_q),
    .i_demand  (i_pos_demand),
    .i_actual  (i_pos_actual),
    .i_window  (window_q),
    .i_timeout (timeout_q),
    .o_outside (outside),
    .o_trip    (trip)
  );

  // error state: a new trip wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fault_q      <= 1'b0;
      o_react_req  <= 1'b0;
      o_react_code <= '0;
    end else begin
      o_react_req <= trip;
      if (trip) begin
        fault_q      <= 1'b1;
        o_react_code <= react_q;
      end else if (clear_req) begin
        fault_q <= 1'b0;
      end
    end
  end

  // pending emergencies; set wins over the clear at transmission
  assign pend_set = {clear_req, trip, dup_set};

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pend_q    <= '0;
      dup_rec_q <= 1'b0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (pend_set[k]) begin
          pend_q[k] <= 1'b1;
        end else if (tx_done && sel_q == dfe_src_t'(k)) begin
          pend_q[k] <= 1'b0;
        end else if (k == DFE_SRC_TRK && clear_req && tx_q == DFE_TX_IDLE) begin
          pend_q[k] <= 1'b0;
        end
      end
      if (dup_set) begin
        dup_rec_q <= 1'b1;
      end else if (tx_done && sel_q == DFE_SRC_DUP) begin
        dup_rec_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_q        <= DFE_TX_IDLE;
      sel_q       <= DFE_SRC_DUP;
      o_emcy_code <= `DFE_EMCY_RESET;
    end else begin
      unique case (tx_q)
        DFE_TX_IDLE: begin
          if (pend_q[DFE_SRC_TRK]) begin
            sel_q       <= DFE_SRC_TRK;
            o_emcy_code <= `DFE_EMCY_TRK;
            tx_q        <= DFE_TX_SEND;
          end else if (pend_q[DFE_SRC_DUP]) begin
            sel_q       <= DFE_SRC_DUP;
            o_emcy_code <= `DFE_EMCY_DUP;
            tx_q        <= DFE_TX_SEND;
          end else if (pend_q[DFE_SRC_RST]) begin
            sel_q       <= DFE_SRC_RST;
            o_emcy_code <= `DFE_EMCY_RESET;
            tx_q        <= DFE_TX_SEND;
          end
        end
        DFE_TX_SEND: begin
          if (i_emcy_ready) begin
            tx_q <= DFE_TX_IDLE;
          end
        end
      endcase
    end
  end

  // error history, newest entry at index 0
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hcnt_q <= '0;
      for (int k = 0; k < HDEPTH; k++) begin
        hist_q[k] <= '0;
      end
    end else if (tx_done && sel_q != DFE_SRC_RST) begin
      hist_q[0] <= {16'h0000, o_emcy_code};
      for (int k = 1; k < HDEPTH; k++) begin
        hist_q[k] <= hist_q[k-1];
      end
      if (hcnt_q != HCW'(HDEPTH)) begin
        hcnt_q <= hcnt_q + 1'b1;
      end
    end else if (acc_wr && i_paddr == `DFE_OFS_HIST_CNT && i_pwdata == '0) begin
      hcnt_q <= '0;
    end
  end

  // configuration registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      window_q   <= `DFE_WINDOW_RST;
      timeout_q  <= `DFE_TIMEOUT_RST;
      react_q    <= `DFE_REACT_RST;
      irq_mask_q <= '0;
    end else if (acc_wr) begin
      unique case (i_paddr)
        `DFE_OFS_WINDOW:   window_q   <= i_pwdata;
        `DFE_OFS_TIMEOUT:  timeout_q  <= i_pwdata[15:0];
        `DFE_OFS_REACT:    react_q    <= i_pwdata[2:0];
        `DFE_OFS_IRQ_MASK: irq_mask_q <= i_pwdata[`DFE_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat_q <= '0;
    end else begin
      for (int k = 0; k < `DFE_IRQ_W; k++) begin
        if ((k == `DFE_IRQ_DUP && dup_set) || (k == `DFE_IRQ_TRK && trip) ||
            (k == `DFE_IRQ_SENT && tx_done)) begin
          irq_stat_q[k] <= 1'b1;
        end else if (acc_wr && i_paddr == `DFE_OFS_IRQ_STAT && i_pwdata[k]) begin
          irq_stat_q[k] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    unique case (i_paddr)
      `DFE_OFS_STATUS: begin
        rdata_d[`DFE_ST_DUP_BIT] = dup_rec_q;
        rdata_d[`DFE_ST_ERR_BIT] = fault_q;
        rdata_d[`DFE_ST_TRK_BIT] = fault_q;
        rdata_d[`DFE_ST_OUT_BIT] = outside;
        rdata_d[`DFE_ST_BLK_LSB +: NOBJ] = o_rx_block;
      end
      `DFE_OFS_IRQ_STAT: rdata_d[`DFE_IRQ_W-1:0] = irq_stat_q;
      `DFE_OFS_IRQ_MASK: rdata_d[`DFE_IRQ_W-1:0] = irq_mask_q;
      `DFE_OFS_WINDOW:   rdata_d = window_q;
      `DFE_OFS_TIMEOUT:  rdata_d[15:0] = timeout_q;
      `DFE_OFS_REACT:    rdata_d[2:0] = react_q;
      `DFE_OFS_HIST_CNT: rdata_d[HCW-1:0] = hcnt_q;
      default: begin
        for (int k = 0; k < NOBJ; k++) begin
          if (i_paddr == slot(`DFE_OFS_COBID_BASE, k)) begin
            rdata_d = cob_q[k];
          end
          if (i_paddr == slot(`DFE_OFS_STORE_BASE, k)) begin
            rdata_d = sto_q[k];
          end
        end
        for (int k = 0; k < HDEPTH; k++) begin
          if (i_paddr == slot(`DFE_OFS_HIST_BASE, k)) begin
            rdata_d = hist_q[k];
          end
        end
      end
    endcase
  end

  // read data captured in the setup cycle, held through access
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ### verification/dfe_fault_report_monitor.sv
// port assertions for the fault reporter
`timescale 1ns/1ps
`default_nettype none
module dfe_fault_report_monitor #(
  parameter int NOBJ = 4
) (
  input wire logic                          i_clk,        // clock
  input wire logic                          i_reset,      // reset
  input wire logic                          i_emcy_ready, // emcy taken
  input wire logic                          o_emcy_valid, // emcy pending
  input wire dfe_pkg::dfe_code_t            o_emcy_code,  // emcy code
  input wire dfe_pkg::dfe_word_t [NOBJ-1:0] o_cob_id,     // identifiers
  input wire logic [NOBJ-1:0]               o_rx_block,   // blocked ids
  input wire logic                          o_status_err, // error bit
  input wire logic                          o_status_trk, // tracking bit
  input wire logic                          o_react_req   // reaction pulse
);
  import dfe_pkg::*;
  logic [NOBJ-1:0] exp_blk;
  // valid ids that share their low 11 bits with another valid id
  always_comb begin
    exp_blk = '0;
    for (int i = 0; i < NOBJ; i++) begin
      for (int j = 0; j < NOBJ; j++) begin
        if (i != j && !o_cob_id[i][31] && !o_cob_id[j][31]
            && o_cob_id[i][10:0] == o_cob_id[j][10:0]) begin
          exp_blk[i] = 1'b1;
        end
      end
    end
  end
  default clocking mcb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  err_bits_a: assert property (o_status_trk |-> o_status_err)
    else $error("tracking bit without error bit");
  react_trk_a: assert property (o_react_req |-> ##[0:2] o_status_trk)
    else $error("reaction without tracking fault");
  react_pulse_a: assert property (o_react_req |=> !o_react_req)
    else $error("reaction request longer than one cycle");
  trk_emcy_a: assert property ($rose(o_status_trk) |-> ##[0:40] (o_emcy_valid && o_emcy_code == 16'h8611))
    else $error("tracking fault not reported");
  emcy_gap_a: assert property (o_emcy_valid && i_emcy_ready |=> !o_emcy_valid)
    else $error("emergency not withdrawn after send");
  dup_block_a: assert property ($changed(o_cob_id) |=> o_rx_block == $past(exp_blk))
    else $error("blocked set differs from duplicates");
  dup_emcy_a: assert property ($rose(|o_rx_block) |-> ##[0:40] (o_emcy_valid && o_emcy_code == 16'h8150))
    else $error("duplicate not reported");
  clr_both_a: assert property ($fell(o_status_err) |-> !o_status_trk ##[0:40]
    (o_emcy_valid && o_emcy_code == 16'h0000))
    else $error("tracking bit or emergency left after clear");
endmodule
bind dfe_fault_report dfe_fault_report_monitor #(.NOBJ(NOBJ)) u_mon (.i_clk, .i_reset,
  .i_emcy_ready, .o_emcy_valid, .o_emcy_code, .o_cob_id, .o_rx_block, .o_status_err,
  .o_status_trk, .o_react_req);
`default_nettype wire

// ### verification/dfe_can_master.sv
// network master model: takes emergencies and sends nmt commands
`timescale 1ns/1ps
`default_nettype none
module dfe_can_master (
  input  wire logic               i_clk,       // clock
  input  wire logic               i_valid,     // emergency pending
  input  wire dfe_pkg::dfe_code_t i_code,      // emergency code
  input  wire logic [3:0]         i_stall,     // wait before taking
  output logic                    o_ready,     // emergency taken
  output logic                    o_nmt_valid, // nmt strobe
  output logic [7:0]              o_nmt_cmd    // nmt code
);
  import dfe_pkg::*;
  logic [3:0] wait_q = 4'h0;
  dfe_code_t  last_code = 16'h0;
  int         n_msg = 0;
  initial begin
    o_ready = 1'b0;
    o_nmt_valid = 1'b0;
    o_nmt_cmd = 8'h00;
  end
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      last_code <= i_code;
      n_msg <= n_msg + 1;
      o_ready <= 1'b0;
      wait_q <= 4'h0;
    end else if (i_valid) begin
      wait_q <= wait_q + 4'h1;
      o_ready <= (wait_q >= i_stall);
    end
  end
  // one-cycle nmt command strobe with the given code
  task automatic send_nmt(input logic [7:0] cmd);
    @(posedge i_clk);
    o_nmt_valid <= 1'b1;
    o_nmt_cmd <= cmd;
    @(posedge i_clk);
    o_nmt_valid <= 1'b0;
    o_nmt_cmd <= ~cmd;
  endtask
endmodule
`default_nettype wire

// ### verification/test_dfe_fault_report.sv
// self-checking bench for the fault reporter
`timescale 1ns/1ps
`default_nettype none
`include "dfe_defines.svh"
module test_dfe_fault_report;
  import dfe_pkg::*;
  logic i_clk = 1'b0, i_reset = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  dfe_word_t i_pwdata = '0, o_prdata, rd;
  logic signed [31:0] i_pos_demand = '0, i_pos_actual = '0;
  logic [3:0] stall = 4'h0, o_rx_block;
  logic [6:0] node = 7'h05;
  dfe_code_t o_emcy_code;
  dfe_react_t o_react_code;
  dfe_word_t [3:0] o_cob_id;
  logic [7:0] i_nmt_cmd;
  logic o_pready, o_pslverr, o_emcy_valid, i_emcy_ready, i_nmt_valid, slv_err;
  logic o_status_err, o_status_trk, o_react_req, o_irq;
  int miscompares = 0, n_tests = 0, n;
  always #2 i_clk = ~i_clk;
  dfe_fault_report #(.NOBJ(4), .HDEPTH(4)) u_dfe_fault_report (.i_clk, .i_reset, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_node_addr(node), .i_nmt_valid, .i_nmt_cmd, .i_pos_demand, .i_pos_actual,
    .o_emcy_valid, .o_emcy_code, .i_emcy_ready, .o_cob_id, .o_rx_block, .o_status_err,
    .o_status_trk, .o_react_req, .o_react_code, .o_irq);
  dfe_can_master u_dfe_can_master (.i_clk, .i_valid(o_emcy_valid), .i_code(o_emcy_code),
    .i_stall(stall), .o_ready(i_emcy_ready), .o_nmt_valid(i_nmt_valid), .o_nmt_cmd(i_nmt_cmd));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input dfe_word_t d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 50);
    rd = o_prdata;
    slv_err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 50) begin
      chk("pready", 0, 1);
      stop_test();
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input dfe_word_t exp);
    apb(1'b0, a, '0);
    chk(what, rd, exp);
  endtask
  task automatic wait_msg(input int m);
    int k;
    k = 0;
    while (u_dfe_can_master.n_msg < m && k < 200) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 200) begin
      chk("emcy wait", 0, 1);
      stop_test();
    end
  endtask
  task automatic t_reset();
    rd_chk("window", `DFE_OFS_WINDOW, 32'h0000_1000);
    rd_chk("timeout", `DFE_OFS_TIMEOUT, 32'h0000_0064);
    rd_chk("react", `DFE_OFS_REACT, 32'h0000_0002);
    chk("id0", o_cob_id[0], 32'h0000_0085);
    chk("id3", o_cob_id[3], 32'h0000_0185);
    rd_chk("unmapped", 8'hfc, 32'h0);
    chk("slverr", slv_err, 1'b1);
  endtask
  task automatic t_dup();
    stall <= 4'h5;
    n = u_dfe_can_master.n_msg;
    apb(1'b1, `DFE_OFS_IRQ_MASK, 32'h1);
    apb(1'b1, `DFE_OFS_COBID_BASE + 8'h04, 32'h0000_0185);
    repeat (2) @(negedge i_clk);
    chk("blk", o_rx_block, 4'ha);
    rd_chk("dup rec", `DFE_OFS_STATUS, 32'h000a_0001);
    wait_msg(n + 1);
    chk("dup code", u_dfe_can_master.last_code, 16'h8150);
    rd_chk("dup gone", `DFE_OFS_STATUS, 32'h000a_0000);
    rd_chk("irq stat", `DFE_OFS_IRQ_STAT, 32'h5);
    chk("irq", o_irq, 1'b1);
    apb(1'b1, `DFE_OFS_IRQ_STAT, 32'h7);
    apb(1'b1, `DFE_OFS_COBID_BASE + 8'h04, 32'h0000_0205);
    repeat (2) @(negedge i_clk);
    chk("irq off", o_irq, 1'b0);
    chk("unblk", o_rx_block, 4'h0);
    stall <= 4'h0;
  endtask
  task automatic t_trk();
    int k;
    n = u_dfe_can_master.n_msg;
    apb(1'b1, `DFE_OFS_WINDOW, 32'd10);
    apb(1'b1, `DFE_OFS_TIMEOUT, 32'd3);
    apb(1'b1, `DFE_OFS_REACT, 32'd5);
    // two short excursions split by a return inside must not trip
    i_pos_actual <= 32'sd11;
    repeat (500) @(posedge i_clk);
    i_pos_actual <= 32'sd0;
    repeat (5) @(posedge i_clk);
    i_pos_actual <= -32'sd11;
    repeat (500) @(posedge i_clk);
    rd_chk("outside", `DFE_OFS_STATUS, 32'h0000_0002);
    k = 0;
    while (o_status_trk !== 1'b1 && k < 1200) begin
      @(posedge i_clk);
      k++;
    end
    chk("trip", k < 1200, 1'b1);
    @(negedge i_clk);
    chk("err bit", o_status_err, 1'b1);
    chk("react", o_react_code, 3'h5);
    rd_chk("trk stat", `DFE_OFS_STATUS, 32'h0000_200a);
    wait_msg(n + 1);
    chk("trk code", u_dfe_can_master.last_code, 16'h8611);
    i_pos_actual <= 32'sd0;
    apb(1'b1, `DFE_OFS_CTRL, 32'h1);
    @(negedge i_clk);
    chk("err clr", {o_status_err, o_status_trk}, 2'b00);
    wait_msg(n + 2);
    chk("reset code", u_dfe_can_master.last_code, 16'h0000);
    rd_chk("hist cnt", `DFE_OFS_HIST_CNT, 32'd2);
    apb(1'b0, `DFE_OFS_HIST_BASE, '0);
    chk("hist0", rd[15:0], 16'h8611);
    apb(1'b0, `DFE_OFS_HIST_BASE + 8'h04, '0);
    chk("hist1", rd[15:0], 16'h8150);
  endtask
  task automatic t_nmt();
    n = u_dfe_can_master.n_msg;
    apb(1'b1, `DFE_OFS_STORE_BASE, 32'h0000_0200);
    u_dfe_can_master.send_nmt(`DFE_NMT_RESET_NODE);
    repeat (6) @(posedge i_clk);
    chk("reload id0", o_cob_id[0], 32'h0000_0205);
    chk("reload blk", o_rx_block, 4'h3);
    wait_msg(n + 1);
    chk("reload code", u_dfe_can_master.last_code, 16'h8150);
    apb(1'b1, `DFE_OFS_STORE_BASE, 32'h0000_0080);
    node <= 7'h0a;
    u_dfe_can_master.send_nmt(`DFE_NMT_RESET_NODE);
    repeat (6) @(posedge i_clk);
    chk("restored id0", o_cob_id[0], 32'h0000_008a);
    chk("restored id2", o_cob_id[2], 32'h0000_030a);
    chk("restored blk", o_rx_block, 4'h0);
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (8) @(posedge i_clk);
    t_reset();
    t_dup();
    t_trk();
    t_nmt();
    stop_test();
  end
endmodule
`default_nettype wire
